/* File: meter_host_uart_port_bench.sv */
`timescale 1ns/100ps
module meter_host_uart_port_bench;
   import mhup_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic rst_pin_n = 1'b1;
   logic rx;
   logic tx;
   logic [15:0] div = 16'h0000;
   logic div_ld = 1'b0;
   logic [7:0] txd = 8'h00;
   logic txv = 1'b0;
   logic tx_ready;
   logic [7:0] rx_data;
   logic rx_valid;
   logic rx_frame_err;
   logic [1:0] cfg = 2'h0;
   logic cfg_ld = 1'b0;
   logic [3:0] src = 4'h0;
   logic do_pin;
   logic running;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   mhup_uart_port #(.RESET_HOLD(20)) dut_u
   (
      .clk(clk), .nrst(nrst), .reset_pin_n(rst_pin_n), .rx(rx), .tx(tx),
      .baud_divisor(div), .baud_load(div_ld), .tx_data(txd),
      .tx_valid(txv), .tx_ready(tx_ready), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_frame_err(rx_frame_err),
      .output_config(cfg), .output_config_load(cfg_ld),
      .energy_pulse(src[0]), .irq_event(src[1]), .zero_cross(src[2]),
      .energy_dir(src[3]), .do_pin(do_pin), .running(running)
   );
   mhup_host_model #(.BIT_CYC(391)) host_u
   (
      .clk(clk), .tx(tx), .rx(rx)
   );
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         error_cnt++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic wait_run();
      for (int n = 0; n < 40 && running !== 1'b1; n++) @(negedge clk);
   endtask : wait_run
   ////////////////////////////////////////////////////////////////////////
   // Byte out on tx while a byte comes in on rx
   task automatic t_duplex();
      logic [7:0] b;
      logic s;
      @(negedge clk);
      div = 16'h8000;
      div_ld = 1'b1;
      @(negedge clk);
      div_ld = 1'b0;
      txd = 8'h4B;
      txv = 1'b1;
      for (int n = 0; n < 10 && tx_ready !== 1'b1; n++) @(negedge clk);
      fork
         host_u.recv(b, s);
         host_u.send(8'hC3, 1'b1);
         begin
            @(negedge clk);
            txv = 1'b0;
            check("tx_ready", tx_ready, 16'h0);
            for (int n = 0; n < 5000 && rx_valid !== 1'b1; n++)
               @(negedge clk);
            check("rx_valid", rx_valid, 16'h1);
            check("rx_data", rx_data, 16'h00C3);
         end
      join
      check("tx byte", b, 16'h004B);
      check("tx stop", s, 16'h1);
      $display("duplex test done");
   endtask : t_duplex
   // Stop bit low gives a frame error
   task automatic t_frame_err();
      fork
         host_u.send(8'h55, 1'b0);
         begin
            for (int n = 0; n < 5000 && rx_frame_err !== 1'b1; n++)
               @(negedge clk);
            check("rx_frame_err", rx_frame_err, 16'h1);
         end
      join
      $display("frame error test done");
   endtask : t_frame_err
   // Each output function routed to do_pin
   task automatic t_do_sel();
      for (int i = 0; i < 4; i++)
      begin
         cfg = 2'(i);
         cfg_ld = 1'b1;
         @(negedge clk);
         cfg_ld = 1'b0;
         src = 4'(1 << i);
         repeat (3) @(negedge clk);
         check("do_pin on", do_pin, 16'h1);
         src = ~src;
         repeat (3) @(negedge clk);
         check("do_pin off", do_pin, 16'h0);
      end
      $display("output select test done");
   endtask : t_do_sel
   // Short low ignored; long low resets and reloads defaults
   task automatic t_reset_pin();
      rst_pin_n = 1'b0;
      repeat (10) @(negedge clk);
      rst_pin_n = 1'b1;
      @(negedge clk);
      check("running short", running, 16'h1);
      rst_pin_n = 1'b0;
      repeat (25) @(negedge clk);
      check("running held", running, 16'h0);
      check("tx held", tx, 16'h1);
      rst_pin_n = 1'b1;
      src = 4'h1;
      wait_run();
      check("running init", running, 16'h1);
      repeat (3) @(negedge clk);
      check("do_pin default", do_pin, 16'h1);
      $display("reset pin test done");
   endtask : t_reset_pin
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      wait_run();
      check("running", running, 16'h1);
      check("tx idle", tx, 16'h1);
      t_duplex();
      t_frame_err();
      t_do_sel();
      t_reset_pin();
      wrap_up();
   end
endmodule : meter_host_uart_port_bench

/* File: mhup_host_model.sv */
`timescale 1ns/100ps
module mhup_host_model
#(
   parameter int unsigned BIT_CYC = 391
)
(
   input  wire logic clk,
   input  wire logic tx,
   output logic      rx
);
   initial rx = 1'b1;
   // Host sends start, data LSB first, stop; idle high
   task automatic send(input logic [7:0] b, input logic stp);
      logic [9:0] f;
      f = {stp, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rx <= f[i];
         repeat (BIT_CYC) @(negedge clk);
      end
      rx <= 1'b1;
      repeat (BIT_CYC) @(negedge clk);
   endtask : send
   // Falling edge starts, each bit sampled mid-period
   task automatic recv(output logic [7:0] b, output logic stp);
      @(negedge tx);
      repeat (BIT_CYC / 2) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CYC) @(negedge clk);
         b[i] = tx;
      end
      repeat (BIT_CYC) @(negedge clk);
      stp = tx;
   endtask : recv
endmodule : mhup_host_model

/* File: mhup_pkg.sv */
package mhup_pkg;

   // Clock figures
   localparam int unsigned CLK_HZ      = 100000000;
   localparam int unsigned CLK_NS      = 10;
   localparam int unsigned MCLK_HZ     = 4096000;
   localparam int unsigned DIV_SCALE   = 524288;

   // Bit timing
   localparam int unsigned OVERSAMPLE  = 16;
   localparam int unsigned ACC_W       = 32;
   localparam longint unsigned ACC_NUM  =
      longint'(MCLK_HZ) * longint'(OVERSAMPLE) * (64'h1 << ACC_W);
   localparam longint unsigned ACC_DEN  =
      longint'(DIV_SCALE) * longint'(CLK_HZ);
   localparam logic [ACC_W-1:0] ACC_STEP =
      ACC_W'((ACC_NUM + ACC_DEN / 2) / ACC_DEN);
   localparam logic [3:0]  SUB_LAST    = 4'hF;
   localparam logic [3:0]  SUB_MID     = 4'h7;

   // Frame layout
   localparam logic [3:0]  BIT_START   = 4'h0;
   localparam logic [3:0]  BIT_STOP    = 4'h9;
   localparam int unsigned FRAME_BITS  = 10;

   // Divisor for 600 baud at the nominal master clock
   localparam logic [15:0] BAUD_DIV_RESET = 16'h004D;

   // Reset pin filter and start-up sequence
   localparam int unsigned RESET_HOLD_NS     = 120000;
   localparam int unsigned RESET_HOLD_CYCLES =
      (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [4:0]  INIT_CYCLES = 5'h10;

   // Digital output function
   typedef enum logic [1:0]
   {
      DO_PULSE = 2'h0,
      DO_IRQ   = 2'h1,
      DO_ZC    = 2'h2,
      DO_DIR   = 2'h3
   } mhup_do_sel_t;

   typedef enum logic [1:0]
   {
      ST_RESET,
      ST_INIT,
      ST_RUN
   } mhup_state_t;

endpackage : mhup_pkg

/* File: mhup_uart_port.sv */
`timescale 1ns/100ps
// Contract
// - reset pin low over 120us resets all; rx_data keeps its last value here
// - release runs init loading default values
// - start, eight data LSB first, stop
// - transmit and receive run independently
// - tx carries out, rx carries in
// - bit rate = 16-bit divisor x MCLK/524288
// - 600 baud default after reset
// - rate never above 512K baud
// - digital output drives one selected function
// - master clock crystal or external source
module mhup_uart_port
   import mhup_pkg::*;
#(
   parameter int unsigned RESET_HOLD = RESET_HOLD_CYCLES
)
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         reset_pin_n,
   input  wire logic         rx,
   output logic              tx,
   input  wire logic [15:0]  baud_divisor,
   input  wire logic         baud_load,
   input  wire logic [7:0]   tx_data,
   input  wire logic         tx_valid,
   output logic              tx_ready,
   output logic [7:0]        rx_data,
   output logic              rx_valid,
   output logic              rx_frame_err,
   input  wire logic [1:0]   output_config,
   input  wire logic         output_config_load,
   input  wire logic         energy_pulse,
   input  wire logic         irq_event,
   input  wire logic         zero_cross,
   input  wire logic         energy_dir,
   output logic              do_pin,
   output logic              running
);

   ////////////////////////////////////////////////////////////////////////
   // Reset pin filter and start-up

   mhup_state_t   state_q, state_d;
   logic [31:0]   hold_q, hold_d;
   logic [4:0]    init_q, init_d;

   always_comb
   begin
      state_d = state_q;
      hold_d  = reset_pin_n ? 32'h0 : hold_q;
      init_d  = init_q;
      if (!reset_pin_n && hold_q < RESET_HOLD)
      begin
         hold_d = hold_q + 32'h1;
      end
      case (state_q)
         ST_RESET:
         begin
            init_d = 5'h0;
            if (reset_pin_n)
            begin
               state_d = ST_INIT;
            end
         end
         ST_INIT:
         begin
            init_d = init_q + 5'h1;
            if (init_q == INIT_CYCLES - 5'h1)
            begin
               state_d = ST_RUN;
            end
         end
         default:
         begin
            state_d = state_q;
         end
      endcase
      if (!reset_pin_n && hold_q >= RESET_HOLD - 1)
      begin
         state_d = ST_RESET;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ST_RESET;
         hold_q  <= 32'h0;
         init_q  <= 5'h0;
      end
      else
      begin
         state_q <= state_d;
         hold_q  <= hold_d;
         init_q  <= init_d;
      end
   end

   assign running = (state_q == ST_RUN);

   ////////////////////////////////////////////////////////////////////////
   // Configuration and bit-rate generator

   logic [15:0]       div_q, div_d;
   mhup_do_sel_t      dosel_q, dosel_d;
   logic [ACC_W-1:0]  acc_q, acc_d;
   logic              tick;
   logic [ACC_W:0]    acc_sum;
   logic [ACC_W-1:0]  acc_inc;

   always_comb
   begin
      div_d   = div_q;
      dosel_d = dosel_q;
      if (!running)
      begin
         div_d   = BAUD_DIV_RESET;
         dosel_d = DO_PULSE;
      end
      else
      begin
         if (baud_load)
         begin
            div_d = baud_divisor;
         end
         if (output_config_load)
         begin
            dosel_d = mhup_do_sel_t'(output_config);
         end
      end
      // Rate = divisor * MCLK / 524288, sixteen ticks per bit
      acc_inc = ACC_W'(ACC_STEP * div_q);
      acc_sum = {1'b0, acc_q} + {1'b0, acc_inc};
      acc_d   = running ? acc_sum[ACC_W-1:0] : '0;
   end

   assign tick = running && acc_sum[ACC_W];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_q   <= BAUD_DIV_RESET;
         dosel_q <= DO_PULSE;
         acc_q   <= '0;
      end
      else
      begin
         div_q   <= div_d;
         dosel_q <= dosel_d;
         acc_q   <= acc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Digital output

   logic do_d;

   always_comb
   begin
      case (dosel_q)
         DO_PULSE: do_d = energy_pulse;
         DO_IRQ:   do_d = irq_event;
         DO_ZC:    do_d = zero_cross;
         DO_DIR:   do_d = energy_dir;
         default:  do_d = 1'b0;
      endcase
      if (!running)
      begin
         do_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         do_pin <= 1'b0;
      end
      else
      begin
         do_pin <= do_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmitter

   logic              tx_busy_q, tx_busy_d;
   logic [3:0]        tx_sub_q, tx_sub_d;
   logic [3:0]        tx_bit_q, tx_bit_d;
   logic [FRAME_BITS-1:0] tx_sh_q, tx_sh_d;

   assign tx_ready = running && !tx_busy_q;

   always_comb
   begin
      tx_busy_d = tx_busy_q;
      tx_sub_d  = tx_sub_q;
      tx_bit_d  = tx_bit_q;
      tx_sh_d   = tx_sh_q;
      if (!running)
      begin
         tx_busy_d = 1'b0;
         tx_sh_d   = '1;
      end
      else if (!tx_busy_q)
      begin
         if (tx_valid)
         begin
            tx_busy_d = 1'b1;
            tx_sub_d  = 4'h0;
            tx_bit_d  = BIT_START;
            tx_sh_d   = {1'b1, tx_data, 1'b0};
         end
      end
      else if (tick)
      begin
         tx_sub_d = tx_sub_q + 4'h1;
         if (tx_sub_q == SUB_LAST)
         begin
            tx_sh_d  = {1'b1, tx_sh_q[FRAME_BITS-1:1]};
            tx_bit_d = tx_bit_q + 4'h1;
            if (tx_bit_q == BIT_STOP)
            begin
               tx_busy_d = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_busy_q <= 1'b0;
         tx_sub_q  <= 4'h0;
         tx_bit_q  <= 4'h0;
         tx_sh_q   <= '1;
      end
      else
      begin
         tx_busy_q <= tx_busy_d;
         tx_sub_q  <= tx_sub_d;
         tx_bit_q  <= tx_bit_d;
         tx_sh_q   <= tx_sh_d;
      end
   end

   assign tx = tx_sh_q[0];

   ////////////////////////////////////////////////////////////////////////
   // Receiver

   logic        rx_prev_q, rx_busy_q, rx_busy_d;
   logic [3:0]  rx_sub_q, rx_sub_d;
   logic [3:0]  rx_bit_q, rx_bit_d;
   logic [7:0]  rx_sh_q, rx_sh_d;
   logic [7:0]  rx_data_d;
   logic        rx_valid_d, rx_err_d;

   always_comb
   begin
      rx_busy_d  = rx_busy_q;
      rx_sub_d   = rx_sub_q;
      rx_bit_d   = rx_bit_q;
      rx_sh_d    = rx_sh_q;
      rx_data_d  = rx_data;
      rx_valid_d = 1'b0;
      rx_err_d   = 1'b0;
      if (!running)
      begin
         rx_busy_d = 1'b0;
      end
      else if (!rx_busy_q)
      begin
         if (rx_prev_q && !rx)
         begin
            rx_busy_d = 1'b1;
            rx_sub_d  = 4'h0;
            rx_bit_d  = BIT_START;
         end
      end
      else if (tick)
      begin
         rx_sub_d = rx_sub_q + 4'h1;
         if (rx_sub_q == SUB_MID)
         begin
            if (rx_bit_q == BIT_START)
            begin
               rx_busy_d = !rx;
            end
            else if (rx_bit_q == BIT_STOP)
            begin
               rx_busy_d  = 1'b0;
               rx_data_d  = rx_sh_q;
               rx_valid_d = rx;
               rx_err_d   = !rx;
            end
            else
            begin
               rx_sh_d = {rx, rx_sh_q[7:1]};
            end
         end
         if (rx_sub_q == SUB_LAST)
         begin
            rx_bit_d = rx_bit_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_prev_q    <= 1'b1;
         rx_busy_q    <= 1'b0;
         rx_sub_q     <= 4'h0;
         rx_bit_q     <= 4'h0;
         rx_sh_q      <= 8'h00;
         rx_data      <= 8'h00;
         rx_valid     <= 1'b0;
         rx_frame_err <= 1'b0;
      end
      else
      begin
         rx_prev_q    <= rx;
         rx_busy_q    <= rx_busy_d;
         rx_sub_q     <= rx_sub_d;
         rx_bit_q     <= rx_bit_d;
         rx_sh_q      <= rx_sh_d;
         rx_data      <= rx_data_d;
         rx_valid     <= rx_valid_d;
         rx_frame_err <= rx_err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_reset_hold: assert property (@(posedge clk) disable iff (!nrst)
      (!reset_pin_n && hold_q == RESET_HOLD - 1) |=> state_q == ST_RESET)
      else $error("reset pin hold did not reset");

   a_reset_glitch: assert property (@(posedge clk) disable iff (!nrst)
      (running && reset_pin_n) |=> running)
      else $error("left run without reset pin");

   a_init_length: assert property (@(posedge clk) disable iff (!nrst)
      $rose(state_q == ST_INIT) |-> !running [*8])
      else $error("init sequence too short");

   a_baud_default: assert property (@(posedge clk) disable iff (!nrst)
      $rose(running) |-> div_q == BAUD_DIV_RESET && dosel_q == DO_PULSE)
      else $error("defaults not loaded at start");

   a_tx_start: assert property (@(posedge clk) disable iff (!nrst)
      (tx_valid && tx_ready) |=> !tx && tx_busy_q)
      else $error("start bit not driven");

   a_tx_stop_end: assert property (@(posedge clk) disable iff (!nrst)
      (tx_busy_q && tick && tx_sub_q == SUB_LAST && tx_bit_q == BIT_STOP)
      |-> tx ##1 !tx_busy_q)
      else $error("frame did not end after stop bit");

   a_tx_idle: assert property (@(posedge clk) disable iff (!nrst)
      !tx_busy_q |-> tx)
      else $error("line not idle high");

   a_rx_pulse: assert property (@(posedge clk) disable iff (!nrst)
      rx_valid |-> !rx_frame_err ##1 !rx_valid)
      else $error("receive strobe not one cycle");

   a_do_select: assert property (@(posedge clk) disable iff (!nrst)
      (running && dosel_q == DO_ZC && $stable(dosel_q)) |=>
         do_pin == $past(zero_cross))
      else $error("digital output wrong source");

endmodule : mhup_uart_port
